// File: rtl/ccu_top.sv
// ccu_top: two capture/compare units with an APB register slave
// assumes: timer counts come from logic on REF_CLK; unit pins are
// asynchronous and synchronised here; timers clear on the pulses
`timescale 1ns/1ps
module ccu_top #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // timer counts
  input  wire logic [15:0] FIRST_TIMER_COUNT,
  input  wire logic [15:0] SECOND_TIMER_COUNT,
  // unit pins, bit 0 unit one
  input  wire logic [1:0]  UNIT_PIN_IN,
  output logic      [1:0]  UNIT_CMP_OUT,
  output logic      [1:0]  UNIT_PIN_OWNED,
  output logic      [1:0]  UNIT_IRQ_FLAG,
  // triggers
  output logic             FIRST_TIMER_CLEAR,
  output logic             SECOND_TIMER_CLEAR,
  output logic             ADC_START
);

  if (CNT_W != 16) begin : g_bad_width
    $error("count width must be 16");
  end

  typedef struct packed {
    logic [7:0]       tsel;
    logic [1:0][15:0] data;
    logic [1:0][7:0]  ctrl;
    logic [1:0]       flag;
    logic [1:0][3:0]  presc;
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic [1:0]       prev;
    logic [1:0]       mprev;
    logic [1:0]       cmp_out;
    logic [1:0]       owned;
    logic             clr1;
    logic             clr2;
    logic             adc;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
  } ccu_state_s;

  ccu_state_s q;
  ccu_state_s d;
  logic [1:0]       cap_ev;
  logic [1:0]       cmp_ev;
  logic [1:0][15:0] cnt;

  // capture modes share the 01xx pattern
  function automatic logic is_cap(input logic [3:0] m);
    return m[3:2] == 2'b01;
  endfunction : is_cap

  // compare modes: toggle and 10xx
  function automatic logic is_cmp(input logic [3:0] m);
    return (m == ccu_pkg::MODE_TOGGLE) || (m[3:2] == 2'b10);
  endfunction : is_cmp

  // second timer chosen for unit u
  function automatic logic use_second(input logic [7:0] t, input int u);
    if (u == 0)
      return t[ccu_pkg::TSEL_HIGH_BIT];
    return t[ccu_pkg::TSEL_HIGH_BIT] | t[ccu_pkg::TSEL_LOW_BIT];
  endfunction : use_second

  // next state: bus, synchronisers, capture and compare
  always_comb begin
    logic        acc;
    logic        wr;
    logic [3:0]  mode;
    logic        rise;
    logic        fall;
    logic        match;
    logic        cwr;
    logic [7:0]  wb;
    logic [31:0] rdat;
    logic        hit;
    acc    = PSEL & PENABLE;
    wr     = acc & q.pready & PWRITE;
    mode   = ccu_pkg::RST_NIB;
    rise   = 1'b0;
    fall   = 1'b0;
    match  = 1'b0;
    cwr    = 1'b0;
    wb     = PWDATA[7:0];
    rdat   = ccu_pkg::RST_WORD;
    hit    = 1'b1;
    cap_ev = 2'b00;
    cmp_ev = 2'b00;
    d      = q;
    d.clr1 = 1'b0;
    d.clr2 = 1'b0;
    d.adc  = 1'b0;
    // read decode, unmapped answers with pslverr
    if (PADDR == ccu_pkg::OFS_TSEL)
      rdat[7:0] = q.tsel;
    else if (PADDR == ccu_pkg::OFS_U1_LOW)
      rdat[7:0] = q.data[0][7:0];
    else if (PADDR == ccu_pkg::OFS_U1_HIGH)
      rdat[7:0] = q.data[0][15:8];
    else if (PADDR == ccu_pkg::OFS_U1_CTRL)
      rdat[7:0] = q.ctrl[0];
    else if (PADDR == ccu_pkg::OFS_U2_LOW)
      rdat[7:0] = q.data[1][7:0];
    else if (PADDR == ccu_pkg::OFS_U2_HIGH)
      rdat[7:0] = q.data[1][15:8];
    else if (PADDR == ccu_pkg::OFS_U2_CTRL)
      rdat[7:0] = q.ctrl[1];
    else if (PADDR == ccu_pkg::OFS_FLAGS)
      rdat[1:0] = q.flag;
    else
      hit = 1'b0;
    // one wait state, then a one-cycle ready
    d.pready  = acc & ~q.pready;
    d.pslverr = acc & ~q.pready & ~hit;
    if (acc && !q.pready)
      d.prdata = rdat;
    // register writes on the completing edge
    if (wr && hit) begin
      if (PADDR == ccu_pkg::OFS_TSEL)
        d.tsel = wb;
      else if (PADDR == ccu_pkg::OFS_U1_LOW)
        d.data[0][7:0] = wb;
      else if (PADDR == ccu_pkg::OFS_U1_HIGH)
        d.data[0][15:8] = wb;
      else if (PADDR == ccu_pkg::OFS_U2_LOW)
        d.data[1][7:0] = wb;
      else if (PADDR == ccu_pkg::OFS_U2_HIGH)
        d.data[1][15:8] = wb;
      else if (PADDR == ccu_pkg::OFS_FLAGS)
        d.flag = q.flag & ~PWDATA[1:0];
    end
    // pin synchronisers; capture sees the real pin level
    d.sync1 = UNIT_PIN_IN;
    d.sync2 = q.sync1;
    // edge history runs in every mode, so a mode change can meet a stale edge
    d.prev  = q.sync2;
    for (int u = 0; u < 2; u++) begin
      cnt[u] = use_second(q.tsel, u) ? SECOND_TIMER_COUNT
                                     : FIRST_TIMER_COUNT;
      cwr  = wr && (PADDR == (u == 0 ? ccu_pkg::OFS_U1_CTRL
                                     : ccu_pkg::OFS_U2_CTRL));
      mode = q.ctrl[u][3:0];
      rise = q.sync2[u] & ~q.prev[u];
      fall = ~q.sync2[u] & q.prev[u];
      // prescaler runs only while capturing
      if (!is_cap(mode))
        d.presc[u] = ccu_pkg::RST_NIB;
      else if (rise)
        d.presc[u] = q.presc[u] + 4'h1;
      case (mode)
        ccu_pkg::MODE_CAP_FALL: cap_ev[u] = fall;
        ccu_pkg::MODE_CAP_RISE: cap_ev[u] = rise;
        ccu_pkg::MODE_CAP_4:
          cap_ev[u] = rise && ((q.presc[u] & ccu_pkg::PRE4_MASK)
                               == ccu_pkg::PRE4_MASK);
        ccu_pkg::MODE_CAP_16:
          cap_ev[u] = rise && (q.presc[u] == ccu_pkg::PRE16_MASK);
        default: cap_ev[u] = 1'b0;
      endcase
      if (cap_ev[u]) begin
        d.data[u] = cnt[u];
        d.flag[u] = 1'b1;
      end
      // compare fires once per entry into equality
      match      = is_cmp(mode) && (q.data[u] == cnt[u]);
      d.mprev[u] = match;
      cmp_ev[u]  = match & ~q.mprev[u] & ~cwr;
      if (cmp_ev[u]) begin
        d.flag[u] = 1'b1;
        case (mode)
          ccu_pkg::MODE_TOGGLE:   d.cmp_out[u] = ~q.cmp_out[u];
          ccu_pkg::MODE_CMP_SET:  d.cmp_out[u] = 1'b1;
          ccu_pkg::MODE_CMP_CLR:  d.cmp_out[u] = 1'b0;
          ccu_pkg::MODE_CMP_TRIG: begin
            if (use_second(q.tsel, u))
              d.clr2 = 1'b1;
            else
              d.clr1 = 1'b1;
            if (u == 1)
              d.adc = 1'b1;
          end
          default: d.cmp_out[u] = q.cmp_out[u];
        endcase
      end
      // set, clear or zero control write sets the starting level of the latch
      if (cwr) begin
        d.ctrl[u] = (u == 1) ? (wb & ccu_pkg::U2_CTRL_MASK) : wb;
        if (wb[3:0] == ccu_pkg::MODE_CMP_CLR)
          d.cmp_out[u] = 1'b1;
        else if (wb[3:0] == ccu_pkg::MODE_CMP_SET || wb == ccu_pkg::RST_BYTE)
          d.cmp_out[u] = 1'b0;
      end
      // pin belongs to the unit in driving compare modes
      d.owned[u] = (d.ctrl[u][3:0] == ccu_pkg::MODE_TOGGLE) ||
                   (d.ctrl[u][3:0] == ccu_pkg::MODE_CMP_SET) ||
                   (d.ctrl[u][3:0] == ccu_pkg::MODE_CMP_CLR);
    end
  end

  // state register
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q.tsel    <= ccu_pkg::RST_BYTE;
      q.data    <= {ccu_pkg::RST_HALF, ccu_pkg::RST_HALF};
      q.ctrl    <= {ccu_pkg::RST_BYTE, ccu_pkg::RST_BYTE};
      q.flag    <= 2'b00;
      q.presc   <= {ccu_pkg::RST_NIB, ccu_pkg::RST_NIB};
      q.sync1   <= 2'b00;
      q.sync2   <= 2'b00;
      q.prev    <= 2'b00;
      q.mprev   <= 2'b00;
      q.cmp_out <= 2'b00;
      q.owned   <= 2'b00;
      q.clr1    <= 1'b0;
      q.clr2    <= 1'b0;
      q.adc     <= 1'b0;
      q.pready  <= 1'b0;
      q.prdata  <= ccu_pkg::RST_WORD;
      q.pslverr <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign PRDATA             = q.prdata;
  assign PREADY             = q.pready;
  assign PSLVERR            = q.pslverr;
  assign UNIT_CMP_OUT       = q.cmp_out;
  assign UNIT_PIN_OWNED     = q.owned;
  assign UNIT_IRQ_FLAG      = q.flag;
  assign FIRST_TIMER_CLEAR  = q.clr1;
  assign SECOND_TIMER_CLEAR = q.clr2;
  assign ADC_START          = q.adc;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // captured value is the assigned count of that edge
  cap_copy_a: assert property (
    cap_ev[0] |=> q.data[0] == $past(cnt[0]))
    else $error("capture did not copy the timer count");

  // capture raises the flag
  cap_flag_a: assert property (
    cap_ev[1] |=> q.flag[1])
    else $error("capture did not set the flag");

  // flag holds until software clears it
  flag_hold_a: assert property (
    q.flag[0] && !(PSEL && PENABLE && PREADY && PWRITE &&
                   PADDR == ccu_pkg::OFS_FLAGS && PWDATA[0]) |=> q.flag[0])
    else $error("flag cleared without a software write");

  // prescaler empty outside capture
  pre_clear_a: assert property (
    !is_cap(q.ctrl[0][3:0]) |=> q.presc[0] == ccu_pkg::RST_NIB)
    else $error("prescaler not cleared outside capture");

  // fourth-edge mode never captures while the prescaler is empty
  pre_four_a: assert property (
    q.ctrl[0][3:0] == ccu_pkg::MODE_CAP_4 && q.presc[0] == ccu_pkg::RST_NIB
    |-> !cap_ev[0])
    else $error("fourth-edge capture fired early");

  // rising mode never captures on a falling edge
  cap_edge_a: assert property (
    q.ctrl[1][3:0] == ccu_pkg::MODE_CAP_RISE && !q.sync2[1] && q.prev[1]
    |-> !cap_ev[1])
    else $error("rising-edge capture took a falling edge");

  // toggle mode inverts the latch on a match
  cmp_toggle_a: assert property (
    cmp_ev[0] && q.ctrl[0][3:0] == ccu_pkg::MODE_TOGGLE
    |=> UNIT_CMP_OUT[0] != $past(UNIT_CMP_OUT[0]) && UNIT_IRQ_FLAG[0])
    else $error("toggle on match failed");

  // set mode drives high on a match
  cmp_set_a: assert property (
    cmp_ev[0] && q.ctrl[0][3:0] == ccu_pkg::MODE_CMP_SET
    |=> UNIT_CMP_OUT[0] ##1 UNIT_CMP_OUT[0] || !$stable(q.ctrl[0]))
    else $error("set on match failed");

  // software interrupt mode leaves the pin alone
  soft_pin_a: assert property (
    cmp_ev[0] && q.ctrl[0][3:0] == ccu_pkg::MODE_CMP_SOFT
    |=> $stable(UNIT_CMP_OUT[0]) && !UNIT_PIN_OWNED[0] && UNIT_IRQ_FLAG[0])
    else $error("software interrupt mode touched the pin");

  // unit two trigger pulses conversion start for one cycle
  trig_adc_a: assert property (
    cmp_ev[1] && q.ctrl[1][3:0] == ccu_pkg::MODE_CMP_TRIG
    |=> ADC_START ##1 !ADC_START)
    else $error("conversion start not a single pulse");

  // trigger clears the timer that serves unit one
  trig_timer_a: assert property (
    cmp_ev[0] && q.ctrl[0][3:0] == ccu_pkg::MODE_CMP_TRIG &&
    !q.tsel[ccu_pkg::TSEL_HIGH_BIT] |=> FIRST_TIMER_CLEAR)
    else $error("trigger missed the assigned timer");

  // unit two trigger on the second timer clears that timer
  trig_second_a: assert property (
    cmp_ev[1] && q.ctrl[1][3:0] == ccu_pkg::MODE_CMP_TRIG && q.tsel[ccu_pkg::TSEL_HIGH_BIT]
    |=> SECOND_TIMER_CLEAR)
    else $error("unit two trigger missed the second timer");

  // select bit 3 hands unit two the second timer
  sel_timer_a: assert property (
    cap_ev[1] && q.tsel[ccu_pkg::TSEL_LOW_BIT] |=> q.data[1] == $past(SECOND_TIMER_COUNT))
    else $error("unit two captured the wrong timer");

  // conversion start comes only from a unit two trigger
  adc_source_a: assert property (
    ADC_START |-> $past(cmp_ev[1] && q.ctrl[1][3:0] == ccu_pkg::MODE_CMP_TRIG))
    else $error("conversion start without a unit two trigger");

  // zero control write leaves the latch low
  zero_ctrl_a: assert property (
    PSEL && PENABLE && PREADY && PWRITE && PADDR == ccu_pkg::OFS_U1_CTRL &&
    PWDATA[7:0] == ccu_pkg::RST_BYTE |=> !UNIT_CMP_OUT[0] && !UNIT_PIN_OWNED[0])
    else $error("latch not cleared by zero control");

  // unit two upper control bits stay zero
  ctrl_bits_a: assert property (
    q.ctrl[1][7:6] == 2'b00)
    else $error("unit two control bits 7:6 set");

  // ready follows one wait state
  apb_ready_a: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb ready timing broken");

endmodule : ccu_top

// File: rtl/ccu_pkg.sv
// ccu_pkg: shared constants of the two capture/compare units
// assumes: byte addresses on an APB slave with 32-bit data
package ccu_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_TSEL     = 8'h00;
  localparam logic [7:0] OFS_U1_LOW   = 8'h04;
  localparam logic [7:0] OFS_U1_HIGH  = 8'h08;
  localparam logic [7:0] OFS_U1_CTRL  = 8'h0c;
  localparam logic [7:0] OFS_U2_LOW   = 8'h10;
  localparam logic [7:0] OFS_U2_HIGH  = 8'h14;
  localparam logic [7:0] OFS_U2_CTRL  = 8'h18;
  localparam logic [7:0] OFS_FLAGS    = 8'h1c;
  // field positions
  localparam int TSEL_HIGH_BIT = 6;
  localparam int TSEL_LOW_BIT  = 3;
  localparam logic [7:0] U2_CTRL_MASK = 8'h3f;
  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  RST_NIB  = 4'h0;
  // mode select field encodings
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_TOGGLE   = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4    = 4'h6;
  localparam logic [3:0] MODE_CAP_16   = 4'h7;
  localparam logic [3:0] MODE_CMP_SET  = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  // prescaler terminal masks
  localparam logic [3:0] PRE4_MASK  = 4'h3;
  localparam logic [3:0] PRE16_MASK = 4'hf;
endpackage : ccu_pkg

// File: test/ccu_pin_model.sv
// ccu_pin_model: real level on the two unit pins
// assumes: bench sets the outside drive, design says who owns each pin
`timescale 1ns/1ps
module ccu_pin_model (
  // outside drive and design side
  input  wire logic [1:0] ext_lvl,
  input  wire logic [1:0] owned,
  input  wire logic [1:0] cmp_out,
  // level seen on the pins
  output logic      [1:0] pin_lvl
);
  // an owned pin shows the compare latch, else the outside level
  assign pin_lvl = (owned & cmp_out) | (~owned & ext_lvl);
endmodule : ccu_pin_model

// File: test/tb.sv
// tb: drives the capture/compare block over APB, pins and timers
// assumes: ccu_pkg, ccu_top and ccu_pin_model compiled first
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic [15:0] cnt1 = 16'h0;
  logic [15:0] cnt2 = 16'h0;
  logic        run = 1'b0;
  logic [1:0]  ext = 2'h0;
  logic [1:0]  pin;
  logic [1:0]  cmp;
  logic [1:0]  own;
  logic [1:0]  flag;
  logic        clr1;
  logic        clr2;
  logic        adc;
  int          err_total = 0;
  int          total_checks = 0;
  int          n_clr1 = 0;
  int          n_clr2 = 0;
  int          n_adc = 0;

  // free running clock
  always #2 clk = ~clk;

  // design and pin partner
  ccu_top i_ccu_top (
    .REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FIRST_TIMER_COUNT(cnt1),
    .SECOND_TIMER_COUNT(cnt2), .UNIT_PIN_IN(pin), .UNIT_CMP_OUT(cmp),
    .UNIT_PIN_OWNED(own), .UNIT_IRQ_FLAG(flag), .FIRST_TIMER_CLEAR(clr1),
    .SECOND_TIMER_CLEAR(clr2), .ADC_START(adc));
  ccu_pin_model i_ccu_pin_model (.ext_lvl(ext), .owned(own), .cmp_out(cmp), .pin_lvl(pin));

  // stand-in timers on the same clock, cleared by trigger pulses
  always @(posedge clk) begin
    n_clr1 += int'(clr1 === 1'b1);
    n_clr2 += int'(clr2 === 1'b1);
    n_adc += int'(adc === 1'b1);
    // timers write only while running or clearing, so task loads do not race them
    if (clr1 === 1'b1)
      cnt1 <= 16'h0000;
    else if (run)
      cnt1 <= cnt1 + 16'h0001;
    if (clr2 === 1'b1)
      cnt2 <= 16'h0000;
    else if (run)
      cnt2 <= cnt2 + 16'h0001;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // one APB transfer, held until pready, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic ctl(input int u, input logic [7:0] v);
    apb(1'b1, ccu_pkg::OFS_U1_CTRL + 8'(12 * u), {24'h0, v});
  endtask : ctl

  task automatic clrf;
    apb(1'b1, ccu_pkg::OFS_FLAGS, 32'h3);
  endtask : clrf

  task automatic rdd(input int u, input logic [15:0] ex);
    apb(1'b0, ccu_pkg::OFS_U1_LOW + 8'(12 * u), 32'h0);
    chk("data low", {24'h0, ex[7:0]}, rd);
    apb(1'b0, ccu_pkg::OFS_U1_HIGH + 8'(12 * u), 32'h0);
    chk("data high", {24'h0, ex[15:8]}, rd);
  endtask : rdd

  // pin high for 6 cycles at count vr, low for 6 at vf; timer two sees the inverse
  task automatic pulse(input int u, input logic [15:0] vr, input logic [15:0] vf);
    cnt1 <= vr;
    cnt2 <= ~vr;
    ext[u] <= 1'b1;
    repeat (6) @(posedge clk);
    cnt1 <= vf;
    cnt2 <= ~vf;
    ext[u] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pulse

  // reset values, unmapped address, unit two control mask
  task automatic t_regs;
    for (int a = 0; a < 36; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset read", 32'h0, rd);
      chk("slave error", {31'h0, a == 32}, {31'h0, er});
    end
    ctl(1, 8'hff);
    apb(1'b0, ccu_pkg::OFS_U2_CTRL, 32'h0);
    chk("unit2 control", 32'h3f, rd);
    ctl(1, 8'h00);
  endtask : t_regs

  // edge choice, sticky flag, silent overwrite
  task automatic t_capture;
    ctl(0, {4'h0, ccu_pkg::MODE_CAP_RISE});
    clrf();
    pulse(0, 16'h0abc, 16'h0111);
    rdd(0, 16'h0abc);
    repeat (20) @(posedge clk);
    chk("flag kept", 32'h1, {31'h0, flag[0]});
    ctl(0, 8'h00);
    ctl(0, {4'h0, ccu_pkg::MODE_CAP_FALL});
    pulse(0, 16'h0222, 16'h1357);
    pulse(0, 16'h0333, 16'h2468);
    rdd(0, 16'h2468);
  endtask : t_capture

  // every fourth and every sixteenth rise, prescaler cleared by mode off
  task automatic t_prescale;
    ctl(0, 8'h00);
    ctl(0, {4'h0, ccu_pkg::MODE_CAP_4});
    clrf();
    for (int i = 1; i < 5; i++) begin
      if (i == 4)
        chk("no capture yet", 32'h0, {31'h0, flag[0]});
      pulse(0, 16'(i), 16'h0000);
    end
    rdd(0, 16'h0004);
    ctl(0, 8'h00);
    ctl(0, {4'h0, ccu_pkg::MODE_CAP_16});
    clrf();
    for (int i = 1; i < 17; i++) begin
      if (i == 16)
        chk("no capture yet", 32'h0, {31'h0, flag[0]});
      pulse(0, 16'(i), 16'h0000);
    end
    rdd(0, 16'h0010);
    chk("flag set", 32'h1, {31'h0, flag[0]});
  endtask : t_prescale

  // timer choice by select bits 3 and 6
  task automatic t_select;
    apb(1'b1, ccu_pkg::OFS_TSEL, 32'h08);
    ctl(0, {4'h0, ccu_pkg::MODE_CAP_RISE});
    ctl(1, {4'h0, ccu_pkg::MODE_CAP_RISE});
    pulse(0, 16'h1111, 16'h0000);
    pulse(1, 16'h3333, 16'h0000);
    rdd(0, 16'h1111);
    rdd(1, 16'hcccc);
    apb(1'b1, ccu_pkg::OFS_TSEL, 32'h40);
    pulse(0, 16'h5555, 16'h0000);
    rdd(0, 16'haaaa);
    ctl(0, 8'h00);
    ctl(1, 8'h00);
    apb(1'b1, ccu_pkg::OFS_TSEL, 32'h00);
  endtask : t_select

  // compare actions on unit one: set, clear, toggle, flag only, then off
  task automatic t_compare;
    logic [3:0] md [4];
    logic [3:0] st;
    logic [3:0] en;
    md = '{ccu_pkg::MODE_CMP_SET, ccu_pkg::MODE_CMP_CLR, ccu_pkg::MODE_TOGGLE,
           ccu_pkg::MODE_CMP_SOFT};
    st = 4'ha;
    en = 4'hd;
    apb(1'b1, ccu_pkg::OFS_U1_LOW, 32'h34);
    apb(1'b1, ccu_pkg::OFS_U1_HIGH, 32'h12);
    for (int k = 0; k < 4; k++) begin
      cnt1 <= 16'h0000;
      ctl(0, {4'h0, md[k]});
      clrf();
      chk("latch start", {31'h0, st[k]}, {31'h0, cmp[0]});
      chk("pin owned", {31'h0, k < 3}, {31'h0, own[0]});
      cnt1 <= 16'h0034;
      repeat (4) @(posedge clk);
      chk("no match", 32'h0, {31'h0, flag[0]});
      cnt1 <= 16'h1234;
      repeat (4) @(posedge clk);
      chk("latch end", {31'h0, en[k]}, {31'h0, cmp[0]});
      chk("match flag", 32'h1, {31'h0, flag[0]});
    end
    ctl(0, 8'h00);
    chk("latch off", 32'h0, {31'h0, cmp[0]});
    cnt1 <= 16'h0000;
  endtask : t_compare

  // one special trigger run of unit u with a compare value of 16, pulses counted
  task automatic trig_run(input int u);
    apb(1'b1, ccu_pkg::OFS_U1_LOW + 8'(12 * u), 32'h10);
    apb(1'b1, ccu_pkg::OFS_U1_HIGH + 8'(12 * u), 32'h00);
    cnt1 <= 16'h0000;
    cnt2 <= 16'h0000;
    ctl(u, {4'h0, ccu_pkg::MODE_CMP_TRIG});
    clrf();
    n_clr1 = 0;
    n_clr2 = 0;
    n_adc = 0;
    run <= 1'b1;
    repeat (24) @(posedge clk);
    run <= 1'b0;
  endtask : trig_run

  // unit two trigger clears timer two and starts a conversion; unit one clears timer one
  task automatic t_trigger;
    apb(1'b1, ccu_pkg::OFS_TSEL, 32'h40);
    trig_run(1);
    chk("timer two clears", 32'h1, 32'(n_clr2));
    chk("timer one clears", 32'h0, 32'(n_clr1));
    chk("conversion starts", 32'h1, 32'(n_adc));
    chk("trigger flag", 32'h1, {31'h0, flag[1]});
    ctl(1, 8'h00);
    apb(1'b1, ccu_pkg::OFS_TSEL, 32'h00);
    trig_run(0);
    chk("unit one timer one clears", 32'h1, 32'(n_clr1));
    chk("unit one timer two clears", 32'h0, 32'(n_clr2));
    chk("unit one conversion starts", 32'h0, 32'(n_adc));
    chk("unit one trigger flag", 32'h1, {31'h0, flag[0]});
    ctl(0, 8'h00);
  endtask : t_trigger

  // reset, then each scenario in turn
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_capture();
    t_prescale();
    t_select();
    t_compare();
    t_trigger();
    end_sim();
  end
endmodule : tb
